// >>> verilog/lsad_defines.vh
// Purpose: constants for the load/store address decode block
// Assumes: 32-bit instruction and data words
// Notes:   field positions follow the transfer instruction encoding
`ifndef LSAD_DEFINES_VH
`define LSAD_DEFINES_VH
`define LSAD_COND_HI      31
`define LSAD_COND_LO      28
`define LSAD_BIT_I        25
`define LSAD_BIT_P        24
`define LSAD_BIT_U        23
`define LSAD_BIT_B        22
`define LSAD_BIT_HIMM     22
`define LSAD_BIT_W        21
`define LSAD_BIT_L        20
`define LSAD_BN_HI        19
`define LSAD_BN_LO        16
`define LSAD_RD_HI        15
`define LSAD_RD_LO        12
`define LSAD_SAMT_HI      11
`define LSAD_SAMT_LO      7
`define LSAD_STYP_HI      6
`define LSAD_STYP_LO      5
`define LSAD_BIT_SREG     4
`define LSAD_BIT_S        6
`define LSAD_BIT_H        5
`define LSAD_PC_IDX       4'hF
`define LSAD_PC_AHEAD     32'h00000008
`define LSAD_BYTE_MASK    32'h000000FF
`define LSAD_HALF_MASK    32'h0000FFFF
`define LSAD_CLS_SDT      2'h1
`define LSAD_CLS_HALF     3'h0
`define LSAD_FLAG_N       3
`define LSAD_FLAG_Z       2
`define LSAD_FLAG_C       1
`define LSAD_FLAG_V       0
`define LSAD_SDT_CLS_HI   27
`define LSAD_SDT_CLS_LO   26
`define LSAD_HALF_CLS_HI  27
`define LSAD_HALF_CLS_LO  25
`define LSAD_BIT_HMARK    7
`define LSAD_IMM12_HI     11
`define LSAD_IMM12_LO     0
`define LSAD_IMM8H_HI     11
`define LSAD_IMM8H_LO     8
`define LSAD_IMM8L_HI     3
`define LSAD_IMM8L_LO     0
`endif

// >>> verilog/lsad_decode.v
// Purpose: decode single and halfword/signed load-store, form address and write-back
// Assumes: register file values arrive on the same clock; one instruction per valid
// Notes:   request and write-back are registered one cycle after instrValid; load results registered one cycle after loadValid
// What this block does
// - byte-select bit set gives a byte transfer, clear gives a word transfer
// - post-indexed single transfer with write-back bit set runs as non-privileged
// - pre-indexed with write-back replaces base with computed address
// - register offsets take only immediate shift amounts, never register shifts
// - pre-indexed register store with write-back writes base+index, then updates base
// - post-indexed store uses unmodified base, then writes base+offset back
// - pre-indexed immediate load without write-back leaves base unchanged
// - register offset shifted left by immediate scales index before adding
// - byte load zero-fills destination bits above the low byte
// - halfword or signed transfer executes only when its condition holds
// - halfword class supports halfword load/store and sign-extended byte/half loads
// - halfword class adds or subtracts offset as encoding selects
// - halfword class writes back address when post-indexed or when auto-indexing requested
// - program counter as base reads as instruction address plus eight
// - post-indexed single transfer always writes back modified base
`include "lsad_defines.vh"
`default_nettype none
module lsad_decode (
	// clock and reset
	input  wire        clk,
	input  wire        srst,
	// instruction in
	input  wire        instrValid,
	input  wire [31:0] instrWord,
	input  wire [31:0] instrAddr,
	input  wire [3:0]  flags,
	input  wire        privMode,
	input  wire [31:0] baseRegVal,
	input  wire [31:0] indexRegVal,
	// memory request
	output reg         memReq_q,
	output reg         memWrite_q,
	output reg  [31:0] memAddr_q,
	output reg  [1:0]  memSize_q,
	output reg         memUserMode_q,
	// load data return, same clock
	input  wire        loadValid,
	input  wire [31:0] loadData,
	output reg         loadSigned_q,
	output reg         destWrite_q,
	output reg  [31:0] destData_q,
	// base write-back
	output reg         baseWrite_q,
	output reg  [3:0]  baseRegIdx_q,
	output reg  [31:0] baseData_q,
	// decode status
	output reg         illegal_q
);
	// flag order in: N Z C V
	wire        n         = flags[`LSAD_FLAG_N];
	wire        z         = flags[`LSAD_FLAG_Z];
	wire        c         = flags[`LSAD_FLAG_C];
	wire        v         = flags[`LSAD_FLAG_V];
	// instruction fields
	wire [3:0]  condField = instrWord[`LSAD_COND_HI:`LSAD_COND_LO];
	wire [1:0]  sdtClass  = instrWord[`LSAD_SDT_CLS_HI:`LSAD_SDT_CLS_LO];
	wire [2:0]  halfClass = instrWord[`LSAD_HALF_CLS_HI:`LSAD_HALF_CLS_LO];
	wire        bitI      = instrWord[`LSAD_BIT_I];
	wire        bitU      = instrWord[`LSAD_BIT_U];
	wire        bitW      = instrWord[`LSAD_BIT_W];
	wire        bitS      = instrWord[`LSAD_BIT_S];
	wire        bitH      = instrWord[`LSAD_BIT_H];
	wire        bitMark   = instrWord[`LSAD_BIT_HMARK];
	wire        bitSreg   = instrWord[`LSAD_BIT_SREG];
	wire [3:0]  baseIdx   = instrWord[`LSAD_BN_HI:`LSAD_BN_LO];
	wire [1:0]  shiftType = instrWord[`LSAD_STYP_HI:`LSAD_STYP_LO];
	wire [11:0] imm12     = instrWord[`LSAD_IMM12_HI:`LSAD_IMM12_LO];
	wire [3:0]  imm8Hi    = instrWord[`LSAD_IMM8H_HI:`LSAD_IMM8H_LO];
	wire [3:0]  imm8Lo    = instrWord[`LSAD_IMM8L_HI:`LSAD_IMM8L_LO];
	reg         condOk;
	reg  [31:0] shifted;
	reg  [31:0] offset;
	reg  [31:0] baseEff;
	reg  [31:0] offAddr;
	reg         isSdt;
	reg         isHalf;
	reg         pre;
	reg         wb;
	reg         bad;
	reg  [1:0]  size;
	reg  [4:0]  samt;
	reg         pendSigned_q;
	reg  [1:0]  pendSize_q;
	reg  [1:0]  pendLane_q;
	reg         take;
	reg  [31:0] lane;

	always @* begin
		case (condField)
			4'h0: condOk = z;
			4'h1: condOk = !z;
			4'h2: condOk = c;
			4'h3: condOk = !c;
			4'h4: condOk = n;
			4'h5: condOk = !n;
			4'h6: condOk = v;
			4'h7: condOk = !v;
			4'h8: condOk = c & !z;
			4'h9: condOk = !c | z;
			4'hA: condOk = n == v;
			4'hB: condOk = n != v;
			4'hC: condOk = !z & (n == v);
			4'hD: condOk = z | (n != v);
			4'hE: condOk = 1'b1;
			// reserved condition treated as never
			default: condOk = 1'b0;
		endcase
	end

	always @* begin
		// immediate shift only; register-shift form flagged illegal
		isSdt  = sdtClass == `LSAD_CLS_SDT;
		isHalf = halfClass == `LSAD_CLS_HALF && bitMark && bitSreg && (bitS | bitH);
		pre    = instrWord[`LSAD_BIT_P];
		samt   = instrWord[`LSAD_SAMT_HI:`LSAD_SAMT_LO];
		bad    = isSdt && bitI && bitSreg;
		take   = instrValid && (isSdt || isHalf) && !bad && condOk;
	end

	// zero amount means 32 for right shifts, one-bit rotate through carry
	always @* begin
		case (shiftType)
			2'h0: shifted = indexRegVal << samt;
			2'h1: shifted = (samt == 5'h00) ? 32'h00000000 : indexRegVal >> samt;
			// spelled out: a signed shift inside ?: would be done unsigned
			2'h2: shifted = (samt == 5'h00) ? {32{indexRegVal[31]}}
				: (indexRegVal >> samt) | ({32{indexRegVal[31]}} & ~(32'hFFFFFFFF >> samt));
			default: shifted = (samt == 5'h00) ? {c, indexRegVal[31:1]}
				: (indexRegVal >> samt) | (indexRegVal << (6'd32 - {1'b0, samt}));
		endcase
	end

	always @* begin
		if (isSdt) begin
			offset = bitI ? shifted : {20'h00000, imm12};
			size   = instrWord[`LSAD_BIT_B] ? 2'h0 : 2'h2;
			wb     = !pre || bitW;
		end else begin
			offset = instrWord[`LSAD_BIT_HIMM] ? {24'h000000, imm8Hi, imm8Lo} : indexRegVal;
			size   = bitH ? 2'h1 : 2'h0;
			wb     = !pre || bitW;
		end
	end

	// program counter base reads ahead of the fetch address
	always @* begin
		baseEff = (baseIdx == `LSAD_PC_IDX)
			? instrAddr + `LSAD_PC_AHEAD : baseRegVal;
		offAddr = bitU ? baseEff + offset : baseEff - offset;
	end

	// request and write-back, registered
	always @(posedge clk) begin
		if (srst) begin
			memReq_q      <= 1'b0;
			memWrite_q    <= 1'b0;
			memAddr_q     <= 32'h00000000;
			memSize_q     <= 2'h0;
			memUserMode_q <= 1'b0;
			baseWrite_q   <= 1'b0;
			baseRegIdx_q  <= 4'h0;
			baseData_q    <= 32'h00000000;
			illegal_q     <= 1'b0;
			pendSigned_q  <= 1'b0;
			pendSize_q    <= 2'h0;
			pendLane_q    <= 2'h0;
		end else begin
			memReq_q    <= 1'b0;
			baseWrite_q <= 1'b0;
			// refused words raise only illegal_q, no access
			illegal_q   <= instrValid && (isSdt || isHalf) && bad;
			if (take) begin
				memReq_q      <= 1'b1;
				memWrite_q    <= !instrWord[`LSAD_BIT_L];
				// pre uses offset address, post the untouched base
				memAddr_q     <= pre ? offAddr : baseEff;
				memSize_q     <= size;
				// forced by translate or by running unprivileged
				memUserMode_q <= !privMode || (isSdt && !pre && bitW);
				baseWrite_q   <= wb;
				baseRegIdx_q  <= instrWord[`LSAD_BN_HI:`LSAD_BN_LO];
				baseData_q    <= offAddr;
				// narrow-load shape held until its data returns
				pendSigned_q  <= isHalf && bitS;
				pendSize_q    <= size;
				pendLane_q    <= (pre ? offAddr[1:0] : baseEff[1:0]);
			end
		end
	end

	// little-endian lane select for narrow loads
	always @* begin
		lane = loadData >> {pendLane_q, 3'h0};
	end

	always @(posedge clk) begin
		if (srst) begin
			destWrite_q  <= 1'b0;
			destData_q   <= 32'h00000000;
			loadSigned_q <= 1'b0;
		end else begin
			destWrite_q  <= loadValid;
			loadSigned_q <= pendSigned_q;
			if (loadValid) begin
				case (pendSize_q)
					2'h0: destData_q <= pendSigned_q ? {{24{lane[7]}}, lane[7:0]}
						: lane & `LSAD_BYTE_MASK;
					2'h1: destData_q <= pendSigned_q ? {{16{lane[15]}}, lane[15:0]}
						: lane & `LSAD_HALF_MASK;
					// misaligned word rotates addressed byte to the bottom
					default: destData_q <= lane | (loadData << (6'd32 - {1'b0, pendLane_q, 3'h0}));
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> verif/lsad_decode_assertions.sv
// Purpose: assertions on the ports of lsad_decode
// Assumes: one clock, srst synchronous active high
// Notes:   al picks always-executed immediate-offset single transfers
`default_nettype none
module lsad_decode_chk (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        instrValid,
	input wire logic [31:0] instrWord,
	input wire logic        loadValid,
	input wire logic        memReq_q,
	input wire logic [1:0]  memSize_q,
	input wire logic        memUserMode_q,
	input wire logic        baseWrite_q,
	input wire logic        destWrite_q,
	input wire logic [31:0] destData_q,
	input wire logic        loadSigned_q,
	input wire logic        illegal_q
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire logic al = instrValid && instrWord[31:26] == 6'h39 && !instrWord[25];
	req_cause_a: assert property (memReq_q |-> $past(instrValid))
		else $error("request without instruction");
	never_cond_a: assert property (instrValid && instrWord[31:28] == 4'hF |=> !memReq_q)
		else $error("never condition made a request");
	illegal_quiet_a: assert property (illegal_q |-> !memReq_q && !baseWrite_q)
		else $error("refused offset made an access");
	wb_req_a: assert property (baseWrite_q |-> memReq_q)
		else $error("write-back without access");
	post_wb_a: assert property (al && !instrWord[24] |=> memReq_q && baseWrite_q)
		else $error("post-indexed without write-back");
	pre_nowb_a: assert property (al && instrWord[24] && !instrWord[21] |=> !baseWrite_q)
		else $error("pre-indexed wrote base");
	byte_size_a: assert property (al && instrWord[22] |=> memSize_q == 2'h0)
		else $error("byte transfer wrong size");
	user_mode_a: assert property (al && !instrWord[24] && instrWord[21] |=> memUserMode_q)
		else $error("translated transfer privileged");
	dest_cause_a: assert property (destWrite_q |-> $past(loadValid))
		else $error("load result without data");
	byte_zero_a: assert property (destWrite_q && !loadSigned_q && memSize_q == 2'h0
		|-> destData_q[31:8] == 24'h000000)
		else $error("byte load upper bits not zero");
	cover property (memReq_q && memUserMode_q);
	cover property (illegal_q);
	cover property (destWrite_q && memSize_q == 2'h0);
endmodule
bind lsad_decode lsad_decode_chk i_lsad_decode_chk (.*);
`default_nettype wire

// >>> verif/lsad_mem_model.sv
// Purpose: memory answering loads of lsad_decode
// Assumes: one load outstanding at a time
// Notes:   lat adds wait cycles; data bus shows garbage when idle
`default_nettype none
module lsad_mem_model (
	input wire logic        clk,
	input wire logic        memReq_q,
	input wire logic        memWrite_q,
	input wire logic [31:0] memAddr_q,
	input wire logic [1:0]  lat,
	output var logic        loadValid,
	output var logic [31:0] loadData
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] word;
	int          waitN = -1;
	initial begin
		loadValid = 1'b0;
		loadData = 32'h0;
	end
	always @(posedge clk) begin
		loadValid <= 1'b0;
		loadData <= ~loadData;
		if (memReq_q && !memWrite_q) begin
			word <= {memAddr_q[31:2], 2'h0} ^ 32'h5AC396F0;
			waitN <= lat;
		end else if (waitN > 0) waitN <= waitN - 1;
		else if (waitN == 0) begin
			loadValid <= 1'b1;
			loadData <= word;
			waitN <= -1;
		end
	end
endmodule
`default_nettype wire

// >>> verif/lsad_decode_tb_top.sv
// Purpose: self-checking bench for lsad_decode
// Assumes: bases word aligned, so word loads never rotate
// Notes:   flags hold Z set, so EQ passes and NE fails
`default_nettype none
module lsad_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, srst = 1'b1, instrValid = 1'b0, privMode = 1'b0, loadValid;
	logic [31:0] instrWord = 32'h0, instrAddr = 32'h0, baseRegVal = 32'h0;
	logic [31:0] indexRegVal = 32'h0, loadData, memAddr_q, destData_q, baseData_q;
	logic [3:0]  flags = 4'h4, baseRegIdx_q;
	logic [1:0]  lat = 2'h0, memSize_q;
	logic        memReq_q, memWrite_q, memUserMode_q, loadSigned_q, destWrite_q;
	logic        baseWrite_q, illegal_q;
	int          n_errors = 0, checks = 0;
	lsad_decode i_lsad_decode (.*);
	lsad_mem_model i_lsad_mem_model (.*);
	initial begin
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] expd(input logic [31:0] a, input int k);
		logic [31:0] w;
		w = ({a[31:2], 2'h0} ^ 32'h5AC396F0) >> (8 * a[1:0]);
		case (k)
			2: expd = {24'h0, w[7:0]};
			3: expd = {{24{w[7]}}, w[7:0]};
			4: expd = {16'h0, w[15:0]};
			5: expd = {{16{w[15]}}, w[15:0]};
			default: expd = w;
		endcase
	endfunction
	task automatic chk(input string n, input logic [31:0] e, s);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// k: -2 refused, -1 skipped, 0 store, above 0 load kind for expd
	task automatic op(input logic [31:0] w, ea, eb, input logic ewb, eu, input int k);
		int t;
		instrWord <= w;
		instrValid <= 1'b1;
		@(posedge clk);
		instrValid <= 1'b0;
		#1;
		chk("request", k >= 0, memReq_q);
		chk("illegal", k == -2, illegal_q);
		chk("writeback", ewb, baseWrite_q);
		if (ewb) chk("base", eb, baseData_q);
		if (ewb) chk("base index", w[19:16], baseRegIdx_q);
		if (k >= 0) chk("address", ea, memAddr_q);
		if (k >= 0) chk("user", eu, memUserMode_q);
		if (k >= 0) chk("write", k == 0, memWrite_q);
		if (k > 0) chk("size", k == 1 ? 2 : k / 4, memSize_q);
		t = 0;
		while (k > 0 && destWrite_q !== 1'b1 && t < 9) begin
			@(posedge clk);
			#1;
			t++;
		end
		if (k > 0) chk("load", expd(ea, k), destData_q);
		if (k > 0) chk("signed", k == 3 || k == 5, loadSigned_q);
	endtask
	task automatic test_done();
		if (n_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		test_done();
	end
	initial begin
		logic [31:0] b, x;
		logic        u;
		void'($urandom(32'h67DA));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (6) begin
			b = $urandom() & 32'hFFFFFFFC;
			x = $urandom() & 32'h00FFFFFC;
			u = $urandom() & 32'h1;
			baseRegVal <= b;
			indexRegVal <= x;
			instrAddr <= b;
			privMode <= !u;
			lat <= 2'($urandom_range(3, 0));
			op(32'hE7A21004, b + x, b + x, 1, u, 0);
			op(32'hE6821004, b, b + x, 1, u, 0);
			op(32'hE5921010, b + 16, 0, 0, u, 1);
			op(32'hE7921103, b + (x << 2), 0, 0, u, 1);
			op(32'hE5D61005, b + 5, 0, 0, u, 2);
			op(32'hE5321010, b - 16, b - 16, 1, u, 1);
			op(32'hE4B21004, b, b + 4, 1, 1, 1);
			op(32'hE59F1008, b + 16, 0, 0, u, 1);
			op(32'hE7921314, 0, 0, 0, 0, -2);
			op(32'hF5921010, 0, 0, 0, 0, -1);
			op(32'h11F210B4, 0, 0, 0, 0, -1);
			op(32'h01D210D4, b + 4, 0, 0, u, 3);
			op(32'hE1F210B4, b + 4, b + 4, 1, u, 4);
			op(32'hE05210F4, b, b - 4, 1, u, 5);
			op(32'hE14210B4, b - 4, 0, 0, u, 0);
		end
		test_done();
	end
endmodule
`default_nettype wire
